// file: rtl/iat_pkg.sv
package iat_pkg;

  // ------------------------------------------------------------
  // Source map
  // ------------------------------------------------------------
  // Index 0 ranks highest in the fixed priority order
  localparam int NUM_SRC = 4;
  localparam int SRC_W = 2;
  localparam logic [SRC_W-1:0] SRC_EXTERNAL_ZERO = 2'h0;
  localparam logic [SRC_W-1:0] SRC_INTERVAL_TIMER = 2'h1;
  localparam logic [SRC_W-1:0] SRC_SERIAL = 2'h2;
  localparam logic [SRC_W-1:0] SRC_TIMER_EVENT = 2'h3;

  // ------------------------------------------------------------
  // Processing status (high bit, low bit)
  // ------------------------------------------------------------
  localparam logic [1:0] STATUS_0 = 2'h0;
  localparam logic [1:0] STATUS_1 = 2'h1;
  localparam logic [1:0] STATUS_2 = 2'h2;
  localparam logic [1:0] STATUS_RESET = STATUS_0;

  // ------------------------------------------------------------
  // Entry sequence and vector layout
  // ------------------------------------------------------------
  localparam int ENTRY_CYCLES = 3;
  localparam int VEC_ADDR_W = 14;
  localparam logic [VEC_ADDR_W-1:0] VEC_ADDR_RESET = 14'h0000;

  // Edge select register: bit 0 picks key falling edge over pin rising edge
  localparam int EDGE_SEL_W = 4;
  localparam int EDGE_SEL_KEY_BIT = 0;
  localparam int KEY_W = 8;

  // Entry sequencer, Gray along the usual path
  typedef enum logic [1:0] {
    IAT_RUN = 2'b00,
    IAT_ENTRY1 = 2'b01,
    IAT_ENTRY2 = 2'b11,
    IAT_ENTRY3 = 2'b10
  } iat_state_type;

endpackage

// file: rtl/iat_flag.sv
`timescale 1ns/10ps
`default_nettype none

// Sticky request flag: hardware or software sets, software or the
// entry sequence clears; a set in the clearing cycle is kept.
module iat_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Set and clear strobes
  input wire logic set,
  input wire logic clr,
  // Flag state
  output logic flag
);

  logic next_flag;

  // Set wins so a late event is never lost
  always_comb begin
    next_flag = flag;
    if (clr) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

// file: rtl/iat_ctrl.sv
// Operation
// - Flag set in last cycle: one more instruction, three-cycle entry, then routine.
// - After interrupt-control instructions, run one further instruction before entry.
// - Global disable right after a request keeps that request pending.
// - Flag set before last cycle: finish instruction, three-cycle entry, routine.
// - Entry loads memory bank and register bank enables from the vector entry.
// - Software-set request flags behave exactly like hardware requests.
// - Reset disables all interrupts and sets status 0.
// - Acceptance needs both the source enable and master enable flags.
// - Low-priority acceptance from status 0 moves to status 1, blocking low requests.
// - Return from service restores status and re-opens blocked interrupts.
// - Requests raised while disabled stay flagged and run once enabled.
// - Two simultaneous low requests: higher fixed priority first, other held.
// - Designated high request beats low one; low ones wait during its routine.
// - Several pending after return: taken one at a time, highest first.
// - Software clearing to status 0 inside a routine allows nesting again.
// - Two test sources: external edge detector and clock timer signal.
// - Test request flag set by its source, cleared only by software.
// - Standby release when a test request and its enable are both one.
// - Clock timer test flag set by timer output, with its own enable.
// - External test flag set by pin rising edge or first key falling edge.
// - High source accepted in status 0 or 1, others only in status 0.
// - Status saved with program status word on entry, restored on return.
`timescale 1ns/10ps
`default_nettype none
module iat_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Instruction sequencer status
  input wire logic instr_last,
  input wire logic instr_is_ei,
  input wire logic instr_is_di,
  input wire logic instr_is_return_from_service,
  input wire logic [1:0] return_from_service_status,
  // Software access to status bits
  input wire logic status_wr,
  input wire logic [1:0] status_wr_data,
  // Interrupt sources
  input wire logic [iat_pkg::NUM_SRC-1:0] hw_request,
  input wire logic [iat_pkg::NUM_SRC-1:0] sw_request_set,
  input wire logic [iat_pkg::NUM_SRC-1:0] sw_request_clr,
  input wire logic [iat_pkg::NUM_SRC-1:0] source_enable_flag,
  // High priority designation
  input wire logic priority_valid,
  input wire logic [iat_pkg::SRC_W-1:0] priority_select_register,
  // Vector table entry of the source on vector_index
  input wire logic vec_memory_bank_enable,
  input wire logic vec_register_bank_enable,
  input wire logic [iat_pkg::VEC_ADDR_W-1:0] vec_start_addr,
  // Test sources and controls
  input wire logic edge_test_input,
  input wire logic [iat_pkg::KEY_W-1:0] key_inputs,
  input wire logic [iat_pkg::EDGE_SEL_W-1:0] edge_select_register,
  input wire logic clock_timer_test_source,
  input wire logic edge_test_enable,
  input wire logic clock_timer_test_enable,
  input wire logic edge_test_clr,
  input wire logic clock_timer_test_clr,
  // Entry sequence to the sequencer
  output logic entry_busy,
  output logic [iat_pkg::SRC_W-1:0] vector_index,
  output logic stack_save,
  output logic [1:0] saved_status,
  output logic service_start,
  output logic [iat_pkg::VEC_ADDR_W-1:0] service_addr,
  output logic memory_bank_enable,
  output logic register_bank_enable,
  // Visible state
  output logic master_enable_flag,
  output logic status_bit_high,
  output logic status_bit_low,
  output logic [iat_pkg::NUM_SRC-1:0] source_request_flag,
  output logic edge_test_request,
  output logic clock_timer_test_request,
  output logic standby_release
);

  import iat_pkg::*;

  // ------------------------------------------------------------
  // Request flags
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] entry_clr;

  // Software sets share the hardware path, so they are handled alike
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      iat_flag u_flag (
        .clk(clk),
        .reset_n(reset_n),
        .set(hw_request[gi] | sw_request_set[gi]),
        .clr(sw_request_clr[gi] | entry_clr[gi]),
        .flag(source_request_flag[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Acceptance and priority
  // ------------------------------------------------------------
  logic [1:0] status;
  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0] high_mask;
  logic [NUM_SRC-1:0] low_ok;
  logic high_ok;
  logic any_ok;
  logic [SRC_W-1:0] pick;
  // Both enables required; flags stay pending while either is off
  assign armed = source_request_flag & source_enable_flag
                 & {NUM_SRC{master_enable_flag}};
  assign high_mask = priority_valid ? (NUM_SRC'(1) << priority_select_register)
                                    : '0;
  // High source in status 0 or 1, low ones only in status 0
  assign high_ok = |(armed & high_mask) && (status != STATUS_2);
  assign low_ok = (status == STATUS_0) ? (armed & ~high_mask) : '0;

  // High one first, then lowest index among the low ones
  always_comb begin
    pick = '0;
    any_ok = 1'b0;
    if (high_ok) begin
      pick = priority_select_register;
      any_ok = 1'b1;
    end else begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (low_ok[i]) begin
          pick = SRC_W'(i);
          any_ok = 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Entry sequencer
  // ------------------------------------------------------------
  iat_state_type state;
  iat_state_type next_state;
  logic accept;
  logic [SRC_W-1:0] next_vector_index;
  // Flags are registered, so a flag set in the last cycle is seen only
  // at the end of the following instruction; control instructions never
  // end in acceptance, which also holds a request across a global disable.
  assign accept = (state == IAT_RUN) && instr_last && any_ok
                  && !instr_is_ei && !instr_is_di;
  assign entry_busy = (state != IAT_RUN);

  // Fixed three-cycle walk after acceptance
  always_comb begin
    next_state = state;
    next_vector_index = vector_index;
    unique case (state)
      IAT_RUN: begin
        if (accept) begin
          next_state = IAT_ENTRY1;
          next_vector_index = pick;
        end
      end
      IAT_ENTRY1: begin
        next_state = IAT_ENTRY2;
      end
      IAT_ENTRY2: begin
        next_state = IAT_ENTRY3;
      end
      IAT_ENTRY3: begin
        next_state = IAT_RUN;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= IAT_RUN;
      vector_index <= '0;
    end else begin
      state <= next_state;
      vector_index <= next_vector_index;
    end
  end

  // Clear the accepted flag in the first entry cycle
  always_comb begin
    entry_clr = '0;
    if (state == IAT_ENTRY1) begin
      entry_clr[vector_index] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Status, master enable, vector loads
  // ------------------------------------------------------------
  logic [1:0] next_status;
  logic next_master;
  logic next_stack_save;
  logic [1:0] next_saved_status;
  logic next_service_start;
  logic [VEC_ADDR_W-1:0] next_service_addr;
  logic next_mbe;
  logic next_rbe;
  // Status steps up at the end of entry; return restores the stacked copy
  always_comb begin
    next_status = status;
    next_master = master_enable_flag;
    next_stack_save = 1'b0;
    next_saved_status = saved_status;
    next_service_start = 1'b0;
    next_service_addr = service_addr;
    next_mbe = memory_bank_enable;
    next_rbe = register_bank_enable;
    if (instr_last && instr_is_ei) begin
      next_master = 1'b1;
    end
    if (instr_last && instr_is_di) begin
      next_master = 1'b0;
    end
    if (status_wr) begin
      next_status = status_wr_data;
    end
    if (instr_last && instr_is_return_from_service) begin
      next_status = return_from_service_status;
    end
    if (state == IAT_ENTRY1) begin
      next_stack_save = 1'b1;
      next_saved_status = status;
    end
    if (state == IAT_ENTRY3) begin
      next_service_start = 1'b1;
      next_service_addr = vec_start_addr;
      next_mbe = vec_memory_bank_enable;
      next_rbe = vec_register_bank_enable;
      next_status = (status == STATUS_0) ? STATUS_1 : STATUS_2;
    end
  end

  // Reset leaves every interrupt disabled in status 0
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= STATUS_RESET;
      master_enable_flag <= 1'b0;
      stack_save <= 1'b0;
      saved_status <= STATUS_RESET;
      service_start <= 1'b0;
      service_addr <= VEC_ADDR_RESET;
      memory_bank_enable <= 1'b0;
      register_bank_enable <= 1'b0;
    end else begin
      status <= next_status;
      master_enable_flag <= next_master;
      stack_save <= next_stack_save;
      saved_status <= next_saved_status;
      service_start <= next_service_start;
      service_addr <= next_service_addr;
      memory_bank_enable <= next_mbe;
      register_bank_enable <= next_rbe;
    end
  end

  assign status_bit_high = status[1];
  assign status_bit_low = status[0];

  // ------------------------------------------------------------
  // Test sources
  // ------------------------------------------------------------
  logic edge_s1;
  logic edge_s2;
  logic edge_d;
  logic [KEY_W-1:0] key_s1;
  logic [KEY_W-1:0] key_s2;
  logic keys_high_d;
  logic next_edge_d;
  logic next_keys_high_d;
  logic edge_event;
  logic key_event;
  logic edge_test_set;
  // Pin inputs pass two flops before any edge logic looks at them
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      edge_s1 <= 1'b0;
      edge_s2 <= 1'b0;
      key_s1 <= '0;
      key_s2 <= '0;
    end else begin
      edge_s1 <= edge_test_input;
      edge_s2 <= edge_s1;
      key_s1 <= key_inputs;
      key_s2 <= key_s1;
    end
  end

  // Edge history; a key held low masks falls on the other keys
  always_comb begin
    next_edge_d = edge_s2;
    next_keys_high_d = &key_s2;
  end

  // History registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      edge_d <= 1'b0;
      keys_high_d <= 1'b0;
    end else begin
      edge_d <= next_edge_d;
      keys_high_d <= next_keys_high_d;
    end
  end

  assign edge_event = edge_s2 & ~edge_d;
  assign key_event = keys_high_d & ~(&key_s2);
  assign edge_test_set = edge_select_register[EDGE_SEL_KEY_BIT]
                         ? key_event : edge_event;

  // Only software clears these; no entry path touches them
  iat_flag u_edge_test (
    .clk(clk),
    .reset_n(reset_n),
    .set(edge_test_set),
    .clr(edge_test_clr),
    .flag(edge_test_request)
  );
  iat_flag u_timer_test (
    .clk(clk),
    .reset_n(reset_n),
    .set(clock_timer_test_source),
    .clr(clock_timer_test_clr),
    .flag(clock_timer_test_request)
  );

  // Release is a level; enables gate it so a cleared enable suppresses it
  assign standby_release = (edge_test_request & edge_test_enable)
                           | (clock_timer_test_request & clock_timer_test_enable);

endmodule

`default_nettype wire

// file: tb/iat_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Entry sequence and test flag checks
// ----------------------------------------
module iat_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Watched inputs
  input wire logic instr_last,
  input wire logic instr_is_ei,
  input wire logic instr_is_di,
  input wire logic clock_timer_test_source,
  input wire logic clock_timer_test_clr,
  input wire logic edge_test_enable,
  input wire logic clock_timer_test_enable,
  // Watched outputs
  input wire logic entry_busy,
  input wire logic stack_save,
  input wire logic [1:0] saved_status,
  input wire logic service_start,
  input wire logic master_enable_flag,
  input wire logic status_bit_high,
  input wire logic status_bit_low,
  input wire logic edge_test_request,
  input wire logic clock_timer_test_request,
  input wire logic standby_release
);
  // One machine-cycle domain, so one clock and one disable for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  entry_three_a: assert property ($rose(entry_busy) |-> entry_busy[*3] ##1 !entry_busy)
    else $error("entry length wrong");
  accept_moment_a: assert property ($rose(entry_busy) |-> $past(instr_last) &&
    !$past(instr_is_ei) && !$past(instr_is_di)) else $error("accept at wrong point");
  master_gate_a: assert property ($rose(entry_busy) |-> $past(master_enable_flag))
    else $error("accept without master enable");
  start_after_a: assert property ($rose(entry_busy) |-> ##3 service_start)
    else $error("routine start late");
  stack_once_a: assert property ($rose(entry_busy) |-> !stack_save ##1 stack_save ##1 !stack_save)
    else $error("stack save pulse wrong");
  status_one_a: assert property (service_start && saved_status == 2'h0 |->
    status_bit_low && !status_bit_high) else $error("status not one");
  status_two_a: assert property (service_start && saved_status == 2'h1 |->
    status_bit_high && !status_bit_low) else $error("status not two");
  release_level_a: assert property (standby_release ==
    (edge_test_request && edge_test_enable || clock_timer_test_request && clock_timer_test_enable))
    else $error("standby release wrong");
  timer_set_a: assert property (clock_timer_test_source |=> clock_timer_test_request)
    else $error("timer test flag not set");
  timer_sticky_a: assert property ($fell(clock_timer_test_request) |-> $past(clock_timer_test_clr))
    else $error("timer test flag self cleared");
endmodule

bind iat_ctrl iat_ctrl_monitor i_iat_ctrl_monitor (.clk, .reset_n, .instr_last, .instr_is_ei,
  .instr_is_di, .clock_timer_test_source, .clock_timer_test_clr, .edge_test_enable,
  .clock_timer_test_enable, .entry_busy, .stack_save, .saved_status, .service_start,
  .master_enable_flag, .status_bit_high, .status_bit_low, .edge_test_request,
  .clock_timer_test_request, .standby_release);
`default_nettype wire

// file: tb/iat_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Instruction sequencer model
// ----------------------------------------
module iat_seq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Entry in progress
  input wire logic entry_busy,
  // End of instruction
  output logic instr_last
);
  logic phase;
  logic next_phase;

  // Two-cycle instructions; fetch stalls while the entry runs
  always_comb begin
    next_phase = entry_busy ? 1'b0 : !phase;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end
  assign instr_last = phase && !entry_busy;
endmodule
`default_nettype wire

// file: tb/iat_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
// ----------------------------------------
// Interrupt accept and test flag bench
// ----------------------------------------
module iat_ctrl_test;
  import iat_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_last, instr_is_ei = 1'b0, instr_is_di = 1'b0, instr_is_return_from_service = 1'b0;
  logic [1:0] return_from_service_status = 2'h0, status_wr_data = 2'h0, priority_select_register = 2'h3;
  logic status_wr = 1'b0, priority_valid = 1'b0, edge_test_input = 1'b0;
  logic [3:0] hw_request = 4'h0, sw_request_set = 4'h0, sw_request_clr = 4'h0;
  logic [3:0] source_enable_flag = 4'h0, edge_select_register = 4'h0;
  logic clock_timer_test_source = 1'b0, edge_test_enable = 1'b0, clock_timer_test_enable = 1'b0;
  logic edge_test_clr = 1'b0, clock_timer_test_clr = 1'b0;
  logic [7:0] key_inputs = 8'hFF;
  logic vec_memory_bank_enable, vec_register_bank_enable, entry_busy, stack_save, service_start;
  logic [13:0] vec_start_addr, service_addr;
  logic memory_bank_enable, register_bank_enable, master_enable_flag, status_bit_high;
  logic status_bit_low, edge_test_request, clock_timer_test_request, standby_release;
  logic [1:0] vector_index, saved_status;
  logic [3:0] source_request_flag;
  int compares = 0, n_mismatch = 0, cycles = 0;

  // Vector table: address and bank enables follow the source index
  assign vec_start_addr = 14'h0100 + {12'h000, vector_index};
  assign vec_memory_bank_enable = vector_index[0];
  assign vec_register_bank_enable = vector_index[1];

  iat_ctrl i_iat_ctrl (.clk, .reset_n, .instr_last, .instr_is_ei, .instr_is_di, .instr_is_return_from_service,
    .return_from_service_status, .status_wr, .status_wr_data, .hw_request, .sw_request_set, .sw_request_clr,
    .source_enable_flag, .priority_valid, .priority_select_register, .vec_memory_bank_enable,
    .vec_register_bank_enable, .vec_start_addr, .edge_test_input, .key_inputs,
    .edge_select_register, .clock_timer_test_source, .edge_test_enable, .clock_timer_test_enable,
    .edge_test_clr, .clock_timer_test_clr, .entry_busy, .vector_index, .stack_save, .saved_status,
    .service_start, .service_addr, .memory_bank_enable, .register_bank_enable, .master_enable_flag,
    .status_bit_high, .status_bit_low, .source_request_flag, .edge_test_request,
    .clock_timer_test_request, .standby_release);
  iat_seq_model i_iat_seq_model (.clk, .reset_n, .entry_busy, .instr_last);

  // Clock and hang guard; the whole run needs well under 2000 cycles
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One instruction of the given kind; ends at its last machine cycle
  task automatic instr(input logic ei, input logic di, input logic return_from_service, input logic [1:0] st);
    instr_is_ei <= ei;
    instr_is_di <= di;
    instr_is_return_from_service <= return_from_service;
    return_from_service_status <= st;
    do @(posedge clk); while (instr_last !== 1'b1);
    instr_is_ei <= 1'b0;
    instr_is_di <= 1'b0;
    instr_is_return_from_service <= 1'b0;
  endtask

  task automatic raise(input logic [3:0] hw, input logic [3:0] sw);
    hw_request <= hw;
    sw_request_set <= sw;
    tick(1);
    hw_request <= 4'h0;
    sw_request_set <= 4'h0;
  endtask

  task automatic expect_entry(input logic [1:0] k, input logic [1:0] st);
    int n;
    n = 0;
    while (service_start !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    `CHK("vector", k, vector_index)
    `CHK("address", 14'h0100 + {12'h000, k}, service_addr)
    `CHK("banks", k, {register_bank_enable, memory_bank_enable})
    `CHK("status", st, {status_bit_high, status_bit_low})
    `CHK("flag cleared", 1'b0, source_request_flag[k])
  endtask

  task automatic return_from_service(input logic [1:0] st);
    instr(1'b0, 1'b0, 1'b1, st);
    tick(1);
    `CHK("status after return", st, {status_bit_high, status_bit_low})
  endtask

  task automatic t_gate;
    source_enable_flag <= 4'hF;
    raise(4'h4, 4'h0);
    tick(8);
    `CHK("held flag", 1'b1, source_request_flag[2])
    `CHK("no entry", 1'b0, entry_busy)
    instr(1'b1, 1'b0, 1'b0, 2'h0);
    instr(1'b0, 1'b1, 1'b0, 2'h0);
    tick(6);
    `CHK("held after disable", 1'b1, source_request_flag[2])
    `CHK("master off", 1'b0, master_enable_flag)
    instr(1'b1, 1'b0, 1'b0, 2'h0);
    expect_entry(2'h2, 2'h1);
    return_from_service(2'h0);
    $display("gate test done");
  endtask

  task automatic t_pair;
    raise(4'h8, 4'h2);
    expect_entry(2'h1, 2'h1);
    tick(8);
    `CHK("low held", 1'b1, source_request_flag[3])
    return_from_service(2'h0);
    expect_entry(2'h3, 2'h1);
    return_from_service(2'h0);
    $display("pair test done");
  endtask

  task automatic t_high;
    priority_valid <= 1'b1;
    raise(4'h9, 4'h0);
    expect_entry(2'h3, 2'h1);
    tick(8);
    `CHK("low waits", 1'b1, source_request_flag[0])
    return_from_service(2'h0);
    expect_entry(2'h0, 2'h1);
    status_wr <= 1'b1;
    tick(1);
    status_wr <= 1'b0;
    raise(4'h2, 4'h0);
    expect_entry(2'h1, 2'h1);
    raise(4'h8, 4'h0);
    expect_entry(2'h3, 2'h2);
    return_from_service(2'h1);
    return_from_service(2'h0);
    return_from_service(2'h0);
    $display("high test done");
  endtask

  task automatic t_test;
    clock_timer_test_source <= 1'b1;
    tick(1);
    clock_timer_test_source <= 1'b0;
    tick(6);
    `CHK("timer flag", 1'b1, clock_timer_test_request)
    `CHK("release masked", 1'b0, standby_release)
    clock_timer_test_enable <= 1'b1;
    tick(2);
    `CHK("release", 1'b1, standby_release)
    clock_timer_test_clr <= 1'b1;
    tick(1);
    clock_timer_test_clr <= 1'b0;
    edge_test_enable <= 1'b1;
    edge_test_input <= 1'b1;
    tick(7);
    `CHK("pin edge flag", 1'b1, edge_test_request)
    `CHK("release from pin", 1'b1, standby_release)
    edge_select_register <= 4'h1;
    tick(6);
    edge_test_clr <= 1'b1;
    tick(1);
    edge_test_clr <= 1'b0;
    key_inputs <= 8'hDF;
    tick(7);
    `CHK("key edge flag", 1'b1, edge_test_request)
    $display("test flag test done");
  endtask

  task automatic t_reset;
    reset_n <= 1'b0;
    tick(16);
    reset_n <= 1'b1;
    tick(1);
    `CHK("master", 1'b0, master_enable_flag)
    `CHK("status", 2'h0, {status_bit_high, status_bit_low})
    `CHK("flags", 4'h0, source_request_flag)
    $display("reset test done");
  endtask

  // Main sequence
  initial begin
    t_reset;
    t_gate;
    t_pair;
    t_high;
    t_test;
    t_reset;
    end_of_test;
  end
endmodule
`default_nettype wire
